// ### sbac_device.sv
`timescale 1ns/1ns
module sbac_device (
  // Clock, reset and run enable
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic I_CE,
  // Power-on straps
  input wire logic I_CFG_LOAD,
  input wire logic I_REINIT_DRV_EN,
  input wire logic I_REINIT_OBS_EN,
  // Core-side status and requests
  input wire logic I_BUS_FAULT,
  input wire logic I_BUSY,
  input wire logic I_REQ,
  input wire logic I_REQ_LOCKED,
  input wire logic I_LOCK_START,
  input wire logic I_LOCK_END,
  input wire logic I_IOQ_PUSH,
  input wire logic I_IOQ_POP,
  // Monitor and debug status
  input wire logic [sbac_pkg::BPM_W-2:0] I_BPM_EVENT,
  input wire logic I_DEBUG_READY,
  // Shared system-bus pins
  sbac_if.device BUS,
  // Status towards the core
  output logic O_REQ_ISSUE,
  output logic O_REINIT_SEEN,
  output logic O_STALLED,
  output logic O_PROBE_REQ,
  output logic O_LOCKED,
  output logic [3:0] O_IOQ_DEPTH,
  output logic [sbac_pkg::BPM_W-1:0] O_BPM_DRV_N
);
  import sbac_pkg::*;

  // All state of the device end, one register
  typedef struct packed {
    logic drv_en;
    logic obs_en;
    logic cfg_done;
    logic reinit_s1;
    logic reinit_s2;
    logic bnr_s1;
    logic bnr_s2;
    logic priority_agent_req_n_s1;
    logic priority_agent_req_n_s2;
    logic probe_request_n_s1;
    logic probe_request_n_s2;
    logic [1:0] phase;
    logic stall;
    logic bnr_drv;
    logic reinit_drv;
    logic reinit_seen;
    logic locked;
    logic [3:0] ioq_depth;
    logic [BPM_W-1:0] bpm;
    sbac_arb_t arb;
  } sbac_dev_t;

  sbac_dev_t st_r;
  sbac_dev_t st_nxt;
  // Decoded conditions
  logic reinit_obs;
  logic may_issue;

  // Synchronised reinit seen only when observation is enabled
  assign reinit_obs = st_r.obs_en & ~st_r.reinit_s2;
  // New requests held off by stall and priority, locked ones pass priority only
  assign may_issue = ~st_r.stall &
                     (st_r.priority_agent_req_n_s2 | st_r.locked);
  assign O_REQ_ISSUE = I_CE & (st_r.arb == SBAC_OWN) & I_REQ &
                       may_issue & (~st_r.priority_agent_req_n_s2 ? I_REQ_LOCKED : 1'h1);

  // Next state
  always_comb begin
    st_nxt = st_r;

    // Pin synchronisers, all on the bus clock
    st_nxt.reinit_s1 = BUS.bus_reinit_n;
    st_nxt.reinit_s2 = st_r.reinit_s1;
    st_nxt.bnr_s1 = BUS.block_next_req_n;
    st_nxt.bnr_s2 = st_r.bnr_s1;
    st_nxt.priority_agent_req_n_s1 = BUS.priority_agent_req_n;
    st_nxt.priority_agent_req_n_s2 = st_r.priority_agent_req_n_s1;
    st_nxt.probe_request_n_s1 = BUS.brkpt_perfmon_n[BPM_PROBE_REQUEST_N_BIT];
    st_nxt.probe_request_n_s2 = st_r.probe_request_n_s1;

    // Straps latched once
    if (I_CFG_LOAD && !st_r.cfg_done) begin
      st_nxt.drv_en = I_REINIT_DRV_EN;
      st_nxt.obs_en = I_REINIT_OBS_EN;
      st_nxt.cfg_done = 1'h1;
    end

    // Stall drive and sample on fixed phases
    st_nxt.phase = (st_r.phase == STALL_PHASE_MAX) ? 2'h0
                                                   : st_r.phase + 2'h1;
    if (st_r.phase == STALL_PHASE_DRIVE) begin
      st_nxt.bnr_drv = I_BUSY;
    end
    if (st_r.phase == STALL_PHASE_SAMPLE) begin
      st_nxt.stall = ~st_r.bnr_s2;
    end

    // Reinit driver
    st_nxt.reinit_drv = st_r.drv_en & I_BUS_FAULT;

    // Lock tracking
    if (I_LOCK_START) begin
      st_nxt.locked = 1'h1;
    end else if (I_LOCK_END) begin
      st_nxt.locked = 1'h0;
    end

    // Arbitration
    case (st_r.arb)
      SBAC_IDLE: begin
        if (I_REQ || st_r.ioq_depth != 4'h0) begin
          st_nxt.arb = SBAC_ARB;
        end
      end
      SBAC_ARB: begin
        if (may_issue) begin
          st_nxt.arb = SBAC_OWN;
        end
      end
      SBAC_OWN: begin
        if (!I_REQ && st_r.ioq_depth == 4'h0) begin
          st_nxt.arb = SBAC_IDLE;
        end
      end
      default: st_nxt.arb = SBAC_IDLE;
    endcase

    // In-order queue depth is left alone by reinit
    if (I_IOQ_PUSH && !I_IOQ_POP && st_r.ioq_depth != 4'hF) begin
      st_nxt.ioq_depth = st_r.ioq_depth + 4'h1;
    end else if (I_IOQ_POP && !I_IOQ_PUSH && st_r.ioq_depth != 4'h0) begin
      st_nxt.ioq_depth = st_r.ioq_depth - 4'h1;
    end

    // Reinit: lock and arbitration reset, then rearbitrate
    if (reinit_obs) begin
      st_nxt.locked = 1'h0;
      st_nxt.arb = (I_REQ || st_r.ioq_depth != 4'h0) ? SBAC_ARB
                                                      : SBAC_IDLE;
      st_nxt.reinit_seen = 1'h1;
    end else if (st_r.arb == SBAC_OWN) begin
      st_nxt.reinit_seen = 1'h0;
    end

    // Breakpoint/monitor outputs, low-true
    st_nxt.bpm[BPM_W-2:0] = ~I_BPM_EVENT;
    st_nxt.bpm[BPM_PROBE_READY_N_BIT] = ~I_DEBUG_READY;
    st_nxt.bpm[BPM_PROBE_REQUEST_N_BIT] = PIN_IDLE;
  end

  // State register
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      st_r <= '{drv_en: 1'h0, obs_en: 1'h0, cfg_done: 1'h0,
                reinit_s1: PIN_IDLE, reinit_s2: PIN_IDLE,
                bnr_s1: PIN_IDLE, bnr_s2: PIN_IDLE,
                priority_agent_req_n_s1: PIN_IDLE, priority_agent_req_n_s2: PIN_IDLE,
                probe_request_n_s1: PIN_IDLE, probe_request_n_s2: PIN_IDLE,
                phase: 2'h0, stall: 1'h0, bnr_drv: 1'h0,
                reinit_drv: 1'h0, reinit_seen: 1'h0, locked: 1'h0,
                ioq_depth: 4'h0, bpm: BPM_IDLE, arb: SBAC_IDLE};
    end else if (I_CE) begin
      st_r <= st_nxt;
    end
  end

  // Pin drivers, open-drain style
  assign BUS.dev_reinit_out_n = 1'h0;
  assign BUS.dev_reinit_oe_n = ~st_r.reinit_drv;
  assign BUS.dev_bnr_out_n = 1'h0;
  assign BUS.dev_bnr_oe_n = ~st_r.bnr_drv;
  assign BUS.dev_bpm_out_n = st_r.bpm;
  always_comb begin
    BUS.dev_bpm_oe_n = {BPM_W{1'h0}};
    BUS.dev_bpm_oe_n[BPM_PROBE_REQUEST_N_BIT] = 1'h1;  // Input pin
  end

  // Status outputs, all from flip-flops
  assign O_REINIT_SEEN = st_r.reinit_seen;
  assign O_STALLED = st_r.stall;
  assign O_PROBE_REQ = ~st_r.probe_request_n_s2;
  assign O_LOCKED = st_r.locked;
  assign O_IOQ_DEPTH = st_r.ioq_depth;
  assign O_BPM_DRV_N = st_r.bpm;
endmodule : sbac_device

// ### sbac_pkg.sv
package sbac_pkg;
  // Width of the breakpoint/monitor group
  localparam int BPM_W = 6;
  // Pin positions inside the breakpoint/monitor group
  localparam int BPM_PROBE_READY_N_BIT = 4;
  localparam int BPM_PROBE_REQUEST_N_BIT = 5;
  // Stall signal is driven and sampled only on every Nth edge
  localparam logic [1:0] STALL_PHASE_MAX = 2'h1;
  localparam logic [1:0] STALL_PHASE_DRIVE = 2'h0;
  localparam logic [1:0] STALL_PHASE_SAMPLE = 2'h1;
  // Inactive (high) level of low-true pins
  localparam logic PIN_IDLE = 1'h1;
  localparam logic [BPM_W-1:0] BPM_IDLE = 6'h3F;

  // Device request arbitration states
  typedef enum logic [1:0] {
    SBAC_IDLE,
    SBAC_ARB,
    SBAC_OWN
  } sbac_arb_t;
endpackage : sbac_pkg

// ### sbac_if.sv
`timescale 1ns/1ns
// Shared low-true pins; each has in, out and output enable per agent, except priority_agent_req_n (agent only) and brkpt_perfmon_n (agent drives bit 5 only)
interface sbac_if;
  logic bus_reinit_n;
  logic dev_reinit_out_n;
  logic dev_reinit_oe_n;
  logic agt_reinit_out_n;
  logic agt_reinit_oe_n;
  logic block_next_req_n;
  logic dev_bnr_out_n;
  logic dev_bnr_oe_n;
  logic agt_bnr_out_n;
  logic agt_bnr_oe_n;
  logic priority_agent_req_n;
  logic [5:0] brkpt_perfmon_n;
  logic [5:0] dev_bpm_out_n;
  logic [5:0] dev_bpm_oe_n;
  logic agt_probe_request_n_out_n;
  logic agt_probe_request_n_oe_n;
  logic [5:0] bpm_wire;

  // Wired-OR of low-true drivers
  assign bus_reinit_n = (dev_reinit_oe_n | dev_reinit_out_n) &
                        (agt_reinit_oe_n | agt_reinit_out_n);
  assign block_next_req_n = (dev_bnr_oe_n | dev_bnr_out_n) &
                            (agt_bnr_oe_n | agt_bnr_out_n);
  always_comb begin
    bpm_wire = dev_bpm_oe_n | dev_bpm_out_n;
    bpm_wire[5] = bpm_wire[5] & (agt_probe_request_n_oe_n | agt_probe_request_n_out_n);
  end
  assign brkpt_perfmon_n = bpm_wire;

  modport device (
    input bus_reinit_n, block_next_req_n, priority_agent_req_n,
    input brkpt_perfmon_n,
    output dev_reinit_out_n, dev_reinit_oe_n, dev_bnr_out_n, dev_bnr_oe_n,
    output dev_bpm_out_n, dev_bpm_oe_n
  );
  modport agent (
    input bus_reinit_n, block_next_req_n, brkpt_perfmon_n,
    output agt_reinit_out_n, agt_reinit_oe_n, agt_bnr_out_n, agt_bnr_oe_n,
    output priority_agent_req_n, agt_probe_request_n_out_n, agt_probe_request_n_oe_n
  );
endinterface : sbac_if

// ### sbac_agent.sv
`timescale 1ns/1ns
// Other party: priority agent, stall source and probe tool
module sbac_agent (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic I_CE,
  input wire logic I_PRI_WANT,
  input wire logic I_PRI_DONE,
  input wire logic I_BUSY,
  input wire logic I_BUS_FAULT,
  input wire logic I_REINIT_DRV_EN,
  input wire logic I_PROBE_REQ,
  sbac_if.agent BUS,
  output logic O_PRI_OWNED,
  output logic O_REINIT_SEEN,
  output logic O_PROBE_READY
);
  import sbac_pkg::*;

  typedef struct packed {
    logic pri;
    logic [1:0] phase;
    logic bnr_drv;
    logic reinit_drv;
    logic probe_request_n;
    logic reinit_s1;
    logic reinit_s2;
    logic probe_ready_n_s1;
    logic probe_ready_n_s2;
  } sbac_agt_t;

  sbac_agt_t st_r;
  sbac_agt_t st_nxt;

  // Next state
  always_comb begin
    st_nxt = st_r;
    // Hold priority until own requests complete
    if (I_PRI_WANT) begin
      st_nxt.pri = 1'h1;
    end else if (I_PRI_DONE) begin
      st_nxt.pri = 1'h0;
    end
    st_nxt.phase = (st_r.phase == STALL_PHASE_MAX) ? 2'h0
                                                   : st_r.phase + 2'h1;
    if (st_r.phase == STALL_PHASE_DRIVE) begin
      st_nxt.bnr_drv = I_BUSY;
    end
    st_nxt.reinit_drv = I_REINIT_DRV_EN & I_BUS_FAULT;
    st_nxt.probe_request_n = I_PROBE_REQ;
    st_nxt.reinit_s1 = BUS.bus_reinit_n;
    st_nxt.reinit_s2 = st_r.reinit_s1;
    st_nxt.probe_ready_n_s1 = BUS.brkpt_perfmon_n[BPM_PROBE_READY_N_BIT];
    st_nxt.probe_ready_n_s2 = st_r.probe_ready_n_s1;
  end

  // State register
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      st_r <= '{pri: 1'h0, phase: 2'h0, bnr_drv: 1'h0, reinit_drv: 1'h0,
                probe_request_n: 1'h0, reinit_s1: PIN_IDLE, reinit_s2: PIN_IDLE,
                probe_ready_n_s1: PIN_IDLE, probe_ready_n_s2: PIN_IDLE};
    end else if (I_CE) begin
      st_r <= st_nxt;
    end
  end

  assign BUS.priority_agent_req_n = ~st_r.pri;
  assign BUS.agt_bnr_out_n = 1'h0;
  assign BUS.agt_bnr_oe_n = ~st_r.bnr_drv;
  assign BUS.agt_reinit_out_n = 1'h0;
  assign BUS.agt_reinit_oe_n = ~st_r.reinit_drv;
  assign BUS.agt_probe_request_n_out_n = 1'h0;
  assign BUS.agt_probe_request_n_oe_n = ~st_r.probe_request_n;
  assign O_PRI_OWNED = st_r.pri;
  assign O_REINIT_SEEN = ~st_r.reinit_s2;
  assign O_PROBE_READY = ~st_r.probe_ready_n_s2;
endmodule : sbac_agent

// ### sbac_chk.sv
`timescale 1ns/1ns
// Timing checks on the shared pins and device answers
module sbac_chk (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic bus_reinit_n,
  input wire logic block_next_req_n,
  input wire logic priority_agent_req_n,
  input wire logic [5:0] brkpt_perfmon_n,
  input wire logic dev_bnr_out_n,
  input wire logic dev_bnr_oe_n,
  input wire logic I_REINIT_DRV_EN,
  input wire logic I_REINIT_OBS_EN,
  input wire logic I_BUS_FAULT,
  input wire logic I_REQ_LOCKED,
  input wire logic I_DEBUG_READY,
  input wire logic O_REQ_ISSUE,
  input wire logic O_STALLED,
  input wire logic O_PROBE_REQ,
  input wire logic O_REINIT_SEEN
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);
  // Level the device puts on the stall wire
  wire logic bnr_lvl = dev_bnr_oe_n | dev_bnr_out_n;
  property p_drv;
    I_BUS_FAULT && I_REINIT_DRV_EN |-> ##[1:3] !bus_reinit_n;
  endproperty
  a_drv: assert property (p_drv) else $error("reinit not driven");
  property p_seen;
    $fell(bus_reinit_n) && I_REINIT_OBS_EN |-> ##[1:4] O_REINIT_SEEN;
  endproperty
  a_seen: assert property (p_seen) else $error("reinit not seen");
  property p_bnr;
    $changed(bnr_lvl) |=> $stable(bnr_lvl);
  endproperty
  a_bnr: assert property (p_bnr) else $error("stall off phase");
  property p_stl;
    !block_next_req_n [*7] |-> O_STALLED;
  endproperty
  a_stl: assert property (p_stl) else $error("stall not seen");
  property p_noiss;
    O_STALLED |-> !O_REQ_ISSUE;
  endproperty
  a_noiss: assert property (p_noiss) else $error("issue in stall");
  property p_pri;
    !priority_agent_req_n [*3] ##0 !I_REQ_LOCKED |-> !O_REQ_ISSUE;
  endproperty
  a_pri: assert property (p_pri) else $error("issue under prio");
  property p_rdy;
    $rose(I_DEBUG_READY) |-> ##[1:3] !brkpt_perfmon_n[4];
  endproperty
  a_rdy: assert property (p_rdy) else $error("no probe ready");
  property p_probe_request_n;
    !brkpt_perfmon_n[5] [*4] |-> O_PROBE_REQ;
  endproperty
  a_probe_request_n: assert property (p_probe_request_n) else $error("no probe req");
endmodule : sbac_chk

// ### tb.sv
`timescale 1ns/1ns
// Both ends joined, driven from their user sides
module tb;
  import sbac_pkg::*;
  logic clk, arst_n, cfg, drv, obs, flt_d, bsy_d, req, rlk, lks, lke;
  logic push, pop, rdy, pw, pd, bsy_a, flt_a, probe_request_n;
  logic iss, seen_d, stl, probe_request_n_d, lkd, pown, seen_a, probe_ready_n_a;
  logic [4:0] ev;
  logic [3:0] dep;
  logic [5:0] bpm_o;
  int errors, total_checks;
  sbac_if sb();
  sbac_device i_sbac_device (.I_CLK(clk), .I_ARST_N(arst_n), .I_CE(1'b1),
    .I_CFG_LOAD(cfg), .I_REINIT_DRV_EN(drv), .I_REINIT_OBS_EN(obs),
    .I_BUS_FAULT(flt_d), .I_BUSY(bsy_d), .I_REQ(req), .I_REQ_LOCKED(rlk),
    .I_LOCK_START(lks), .I_LOCK_END(lke), .I_IOQ_PUSH(push),
    .I_IOQ_POP(pop), .I_BPM_EVENT(ev), .I_DEBUG_READY(rdy), .BUS(sb),
    .O_REQ_ISSUE(iss), .O_REINIT_SEEN(seen_d), .O_STALLED(stl),
    .O_PROBE_REQ(probe_request_n_d), .O_LOCKED(lkd), .O_IOQ_DEPTH(dep),
    .O_BPM_DRV_N(bpm_o));
  sbac_agent i_sbac_agent (.I_CLK(clk), .I_ARST_N(arst_n), .I_CE(1'b1),
    .I_PRI_WANT(pw), .I_PRI_DONE(pd), .I_BUSY(bsy_a), .I_BUS_FAULT(flt_a),
    .I_REINIT_DRV_EN(1'b1), .I_PROBE_REQ(probe_request_n), .BUS(sb),
    .O_PRI_OWNED(pown), .O_REINIT_SEEN(seen_a), .O_PROBE_READY(probe_ready_n_a));
  sbac_chk i_sbac_chk (.I_CLK(clk), .I_ARST_N(arst_n),
    .bus_reinit_n(sb.bus_reinit_n), .block_next_req_n(sb.block_next_req_n),
    .priority_agent_req_n(sb.priority_agent_req_n),
    .brkpt_perfmon_n(sb.brkpt_perfmon_n), .dev_bnr_out_n(sb.dev_bnr_out_n),
    .dev_bnr_oe_n(sb.dev_bnr_oe_n), .I_REINIT_DRV_EN(drv),
    .I_REINIT_OBS_EN(obs), .I_BUS_FAULT(flt_d), .I_REQ_LOCKED(rlk),
    .I_DEBUG_READY(rdy), .O_REQ_ISSUE(iss), .O_STALLED(stl),
    .O_PROBE_REQ(probe_request_n_d), .O_REINIT_SEEN(seen_d));
  // Bus clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Wait edges, then settle a little
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tk
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // Bounded wait for a level
  task automatic wt(ref logic s, input logic v);
    for (int k = 0; k < 30 && s !== v; k++) tk(1);
    // A wait that runs out is a mismatch
    if (s !== v) begin
      errors++;
      $display("unexpected %0t wait for level timed out", $time);
    end
  endtask : wt
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done
  // Reset with straps, check idle pins, then load straps
  task automatic rst(input logic o, input logic d);
    obs = o;
    drv = d;
    arst_n = 1'b0;
    tk(20);
    chk(8'({sb.bus_reinit_n, sb.block_next_req_n, stl}), 8'h06);
    chk(8'(sb.brkpt_perfmon_n), 8'(BPM_IDLE));
    arst_n = 1'b1;
    tk(1);
    cfg = 1'b1;
    tk(1);
    cfg = 1'b0;
  endtask : rst
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  // Watchdog
  initial begin
    #20000;
    errors++;
    end_sim();
  end
  // Test sequence
  initial begin
    {cfg, flt_d, bsy_d, req, rlk, lks, lke, push, pop, rdy} = '0;
    {pw, pd, bsy_a, flt_a, probe_request_n, ev} = '0;
    errors = 0;
    total_checks = 0;
    rst(1'b1, 1'b1);
    req = 1'b1;
    wt(iss, 1'b1);
    chk(8'(iss), 8'h01);
    bsy_a = 1'b1;
    wt(stl, 1'b1);
    tk(2);
    chk(8'({stl, iss}), 8'h02);
    bsy_a = 1'b0;
    wt(stl, 1'b0);
    bsy_d = 1'b1;
    tk(6);
    chk(8'(sb.block_next_req_n), 8'h00);
    bsy_d = 1'b0;
    wt(iss, 1'b1);
    done("stall");
    pw = 1'b1;
    tk(1);
    pw = 1'b0;
    wt(pown, 1'b1);
    tk(4);
    chk(8'({pown, sb.priority_agent_req_n, iss}), 8'h04);
    rlk = 1'b1;
    lks = 1'b1;
    tk(1);
    lks = 1'b0;
    wt(iss, 1'b1);
    chk(8'({lkd, iss}), 8'h03);
    rlk = 1'b0;
    pd = 1'b1;
    tk(1);
    pd = 1'b0;
    wt(iss, 1'b1);
    chk(8'({pown, sb.priority_agent_req_n}), 8'h01);
    done("priority");
    push = 1'b1;
    tk(3);
    push = 1'b0;
    pop = 1'b1;
    tk(1);
    pop = 1'b0;
    flt_d = 1'b1;
    tk(2);
    flt_d = 1'b0;
    wt(seen_a, 1'b1);
    chk(8'(seen_a), 8'h01);
    wt(seen_d, 1'b1);
    chk(8'({seen_d, lkd, dep}), 8'h22);
    wt(iss, 1'b1);
    chk(8'(iss), 8'h01);
    done("reinit");
    ev = 5'h0A;
    rdy = 1'b1;
    tk(3);
    chk(8'(sb.brkpt_perfmon_n[3:0]), 8'h05);
    chk(8'(bpm_o), 8'h25);
    wt(probe_ready_n_a, 1'b1);
    chk(8'({probe_ready_n_a, sb.brkpt_perfmon_n[4]}), 8'h02);
    probe_request_n = 1'b1;
    wt(probe_request_n_d, 1'b1);
    chk(8'({probe_request_n_d, sb.brkpt_perfmon_n[5]}), 8'h02);
    done("monitor");
    rst(1'b0, 1'b0);
    flt_d = 1'b1;
    tk(8);
    chk(8'({seen_a, sb.bus_reinit_n}), 8'h01);
    flt_d = 1'b0;
    flt_a = 1'b1;
    tk(8);
    chk(8'(seen_d), 8'h00);
    done("straps");
    end_sim();
  end
endmodule : tb
